// ==== logic/mcl_pkg.sv ====
// constants for the machine-check status logger
package mcl_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_STAT_LO = 12'h000;
  localparam logic [11:0] OFS_STAT_HI = 12'h004;
  localparam logic [11:0] OFS_FAULT   = 12'h008;
  localparam logic [11:0] OFS_EXTRA   = 12'h00c;
  localparam logic [11:0] OFS_PERMIT  = 12'h010;

  // flag positions in the 64-bit log
  localparam int BIT_CTX  = 57;
  localparam int BIT_LOC  = 58;
  localparam int BIT_XTRA = 59;
  localparam int BIT_RPT  = 60;
  localparam int BIT_NCOR = 61;
  localparam int BIT_LOST = 62;
  localparam int BIT_LOGD = 63;

  // field positions
  localparam int CODE_LSB   = 0;
  localparam int DETAIL_LSB = 16;
  localparam int CNT_LSB    = 32;
  localparam int FMT_LSB    = 40;

  // primary fault codes
  localparam logic [15:0] CODE_INTERNAL = 16'h0400;
  localparam logic [15:0] CODE_L3_TAG   = 16'h010b;
  localparam logic [15:0] CODE_BUS      = 16'h0e0f;

  localparam logic [7:0]  CNT_MAX     = 8'hff;
  localparam logic [7:0]  CNT_RST     = 8'h00;
  localparam logic [63:0] STAT_RST    = 64'h0;
  localparam logic [31:0] WORD_RST    = 32'h0;
  localparam logic [2:0]  PERMIT_RST  = 3'h0;

  typedef enum logic [1:0] {
    MCL_KIND_INTERNAL,
    MCL_KIND_L3_TAG,
    MCL_KIND_BUS
  } mcl_kind_t;
endpackage

// ==== logic/mcl_entry_if.sv ====
// candidate log entry passed from the encoder to the logger
`timescale 1ns/1ns
interface mcl_entry_if;
  logic        valid;
  logic [63:0] word;
  logic        uc;
  logic        en;
  logic [31:0] addr;
  logic [31:0] misc;

  modport enc (output valid, output word, output uc, output en, output addr, output misc);
  modport log (input valid, input word, input uc, input en, input addr, input misc);
endinterface

// ==== logic/mcl_encoder.sv ====
// builds a complete status word for one reported error
`timescale 1ns/1ns
module mcl_encoder (
  input  wire logic              err_valid,
  input  wire mcl_pkg::mcl_kind_t err_kind,
  input  wire logic              err_uncorr,
  input  wire logic              err_ctx,
  input  wire logic              err_loc_ok,
  input  wire logic [31:0]       err_loc,
  input  wire logic              err_xtra_ok,
  input  wire logic [31:0]       err_xtra,
  input  wire logic [1:0]        err_xtra_fmt,
  input  wire logic [15:0]       err_detail,
  input  wire logic [2:0]        permit,
  input  wire logic [7:0]        corr_count,
  mcl_entry_if.enc               ent
);
  // ----------------------------------------------------------------
  // fault code lookup
  // ----------------------------------------------------------------
  // only the three used encodings can come out; reserved bus codes never do
  function automatic logic [15:0] fault_code(input mcl_pkg::mcl_kind_t k);
    case (k)
      mcl_pkg::MCL_KIND_L3_TAG: fault_code = mcl_pkg::CODE_L3_TAG;
      mcl_pkg::MCL_KIND_BUS:    fault_code = mcl_pkg::CODE_BUS;
      default:                  fault_code = mcl_pkg::CODE_INTERNAL;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // entry assembly
  // ----------------------------------------------------------------
  logic       rpt;
  logic       ctx;
  logic [1:0] kidx;

  // the unused kind code is handled as internal, so it never indexes past the permit bits
  assign kidx = (err_kind == mcl_pkg::mcl_kind_t'(2'h3)) ? 2'h0 : err_kind;

  // the permit bit is gated by err_uncorr, so a correctable error never reports enabled
  assign rpt = err_uncorr & permit[kidx];
  assign ctx = err_uncorr | err_ctx;

  always_comb begin
    ent.word = mcl_pkg::STAT_RST;
    ent.word[mcl_pkg::CODE_LSB +: 16]   = fault_code(err_kind);
    ent.word[mcl_pkg::DETAIL_LSB +: 16] = err_detail;
    ent.word[mcl_pkg::CNT_LSB +: 8]     = corr_count;
    ent.word[mcl_pkg::FMT_LSB +: 2]     = err_xtra_fmt;
    ent.word[mcl_pkg::BIT_CTX]  = ctx;
    ent.word[mcl_pkg::BIT_LOC]  = err_loc_ok;
    ent.word[mcl_pkg::BIT_XTRA] = err_xtra_ok;
    ent.word[mcl_pkg::BIT_RPT]  = rpt;
    ent.word[mcl_pkg::BIT_NCOR] = err_uncorr;
    ent.word[mcl_pkg::BIT_LOGD] = 1'b1;
  end

  assign ent.valid = err_valid;
  assign ent.uc    = err_uncorr;
  assign ent.en    = rpt;
  assign ent.addr  = err_loc;
  assign ent.misc  = err_xtra;
endmodule

// ==== logic/mcl_logger.sv ====
// machine-check status logger: bank log, overwrite priority, apb slave
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ns

// Overview of operation
// - context damaged set when uncorrected or corrupting
// - location flag set only with valid address
// - extra info flag set only with info
// - report flag reflects the permit bit
// - correctable errors never set report flag
// - not corrected flag follows correction result
// - lost flag set on error while logged
// - lost flag cleared only by software
// - enabled over disabled only when the logged entry is corrected, uncorrected over corrected
// - uncorrected entry never replaced by uncorrected
// - logged flag set on log, software clears
// - internal error code is 0400
// - cache tag error code is 010b
// - bus error code is 0e0f
// - reserved bus encodings never produced
// - model detail goes into bits 31:16
// - count in bits 39:32, extra format in bits 41:40
// - detail high half, fault code low half
module mcl_logger #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clock,
  input  wire logic              reset,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // error report from the core
  input  wire logic              err_valid,
  input  wire mcl_pkg::mcl_kind_t err_kind,
  input  wire logic              err_uncorr,
  input  wire logic              err_ctx,
  input  wire logic              err_loc_ok,
  input  wire logic [31:0]       err_loc,
  input  wire logic              err_xtra_ok,
  input  wire logic [31:0]       err_xtra,
  input  wire logic [1:0]        err_xtra_fmt,
  input  wire logic [15:0]       err_detail,
  // status levels
  output logic                   entry_logged,
  output logic                   lost_error
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [63:0] stat_r;
  logic [63:0] stat_nxt;
  logic [31:0] fault_r;
  logic [31:0] fault_nxt;
  logic [31:0] extra_r;
  logic [31:0] extra_nxt;
  logic [2:0]  permit_r;
  logic [2:0]  permit_nxt;
  logic [7:0]  cnt_r;
  logic [7:0]  cnt_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  mcl_entry_if ent ();

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  wire hit_lo     = hit(paddr, mcl_pkg::OFS_STAT_LO);
  wire hit_hi     = hit(paddr, mcl_pkg::OFS_STAT_HI);
  wire hit_fault  = hit(paddr, mcl_pkg::OFS_FAULT);
  wire hit_extra  = hit(paddr, mcl_pkg::OFS_EXTRA);
  wire hit_permit = hit(paddr, mcl_pkg::OFS_PERMIT);
  wire mapped     = hit_lo | hit_hi | hit_fault | hit_extra | hit_permit;

  wire setup  = psel & ~penable;
  wire access = psel & penable;
  wire wr_ok  = access & pwrite & mapped;

  // zero wait states: read data is captured in the setup cycle
  assign pready  = access;
  assign pslverr = access & ~mapped;
  assign prdata  = prdata_r;

  // ----------------------------------------------------------------
  // software clear
  // ----------------------------------------------------------------
  // writes can only clear bits; a written zero word empties that half
  wire [31:0] lo_mask = (wr_ok & hit_lo) ? pwdata : 32'hffffffff;
  wire [31:0] hi_mask = (wr_ok & hit_hi) ? pwdata : 32'hffffffff;

  wire [63:0] base = stat_r & {hi_mask, lo_mask};

  wire base_logd = base[mcl_pkg::BIT_LOGD];
  wire base_uc   = base[mcl_pkg::BIT_NCOR];
  wire base_en   = base[mcl_pkg::BIT_RPT];
  wire base_lost = base[mcl_pkg::BIT_LOST];

  // ----------------------------------------------------------------
  // overwrite priority
  // ----------------------------------------------------------------
  // a clear landing in the same cycle as an error is applied first,
  // so the new error finds an empty bank and is not lost
  wire both_uc  = base_uc & ent.uc;
  wire promote  = (ent.en & ~base_en) | (ent.uc & ~base_uc);
  wire take     = ent.valid & (~base_logd | (~both_uc & promote));
  wire lost_set = ent.valid & base_logd;

  always_comb begin
    stat_nxt = take ? ent.word : base;
    // lost flag only ever set here; cleared only through base
    stat_nxt[mcl_pkg::BIT_LOST] = base_lost | lost_set;
  end

  // address and extra info travel with the entry they describe
  assign fault_nxt = take ? ent.addr : fault_r;
  assign extra_nxt = take ? ent.misc : extra_r;

  // ----------------------------------------------------------------
  // correctable event count
  // ----------------------------------------------------------------
  // saturating, counts since reset; first correctable event reads 1
  wire cnt_inc = err_valid & ~err_uncorr & (cnt_r != mcl_pkg::CNT_MAX);

  assign cnt_nxt = cnt_inc ? cnt_r + 8'h01 : cnt_r;

  // ----------------------------------------------------------------
  // permit register
  // ----------------------------------------------------------------
  assign permit_nxt = (wr_ok & hit_permit) ? pwdata[2:0] : permit_r;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    prdata_nxt = prdata_r;
    if (setup) begin
      prdata_nxt = 32'h0;
      if (hit_lo) begin
        prdata_nxt = stat_r[31:0];
      end
      if (hit_hi) begin
        prdata_nxt = stat_r[63:32];
      end
      if (hit_fault) begin
        prdata_nxt = fault_r;
      end
      if (hit_extra) begin
        prdata_nxt = extra_r;
      end
      if (hit_permit) begin
        prdata_nxt = {29'h0, permit_r};
      end
    end
  end

  // ----------------------------------------------------------------
  // entry encoder
  // ----------------------------------------------------------------
  mcl_encoder u_encoder (
    .err_valid    (err_valid),
    .err_kind     (err_kind),
    .err_uncorr   (err_uncorr),
    .err_ctx      (err_ctx),
    .err_loc_ok   (err_loc_ok),
    .err_loc      (err_loc),
    .err_xtra_ok  (err_xtra_ok),
    .err_xtra     (err_xtra),
    .err_xtra_fmt (err_xtra_fmt),
    .err_detail   (err_detail),
    .permit       (permit_r),
    .corr_count   (cnt_nxt),
    .ent          (ent.enc)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      stat_r <= mcl_pkg::STAT_RST;
      fault_r <= mcl_pkg::WORD_RST;
      extra_r <= mcl_pkg::WORD_RST;
    end else begin
      stat_r <= stat_nxt;
      fault_r <= fault_nxt;
      extra_r <= extra_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      permit_r <= mcl_pkg::PERMIT_RST;
      cnt_r <= mcl_pkg::CNT_RST;
      prdata_r <= mcl_pkg::WORD_RST;
    end else begin
      permit_r <= permit_nxt;
      cnt_r <= cnt_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  assign entry_logged = stat_r[mcl_pkg::BIT_LOGD];
  assign lost_error   = stat_r[mcl_pkg::BIT_LOST];
endmodule

// ==== bench/mcl_logger_props.sv ====
// concurrent checks on the status logger ports
`timescale 1ns/1ns
module mcl_logger_props #(
  parameter int ADDR_W = 12
) (
  input wire logic              clock,
  input wire logic              reset,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              err_valid,
  input wire logic              entry_logged,
  input wire logic              lost_error
);
  // -----------------------------------------
  // properties
  // -----------------------------------------
  // any write to the high word may clear flags, so such cycles are excluded
  wire hi_wr = psel && penable && pwrite && paddr == ADDR_W'(mcl_pkg::OFS_STAT_HI);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  property p_log_set; err_valid |=> entry_logged; endproperty
  property p_lost_set; err_valid && entry_logged && !hi_wr |=> lost_error; endproperty
  property p_lost_keep; lost_error && !hi_wr |=> lost_error; endproperty
  property p_lost_cause; $rose(lost_error) |-> $past(err_valid) && $past(entry_logged);
  endproperty
  property p_log_keep; entry_logged && !hi_wr |=> entry_logged; endproperty
  property p_log_cause; $rose(entry_logged) |-> $past(err_valid); endproperty
  property p_clear;
    hi_wr && pwdata[31:30] == 2'h0 && !err_valid |=> !entry_logged && !lost_error;
  endproperty
  property p_fresh;
    err_valid && !entry_logged && !lost_error |=> entry_logged && !lost_error;
  endproperty
  a_log_set: assert property (p_log_set) else $error("entry not logged");
  a_lost_set: assert property (p_lost_set) else $error("lost flag missed");
  a_lost_keep: assert property (p_lost_keep) else $error("lost flag dropped");
  a_lost_cause: assert property (p_lost_cause) else $error("lost flag unprompted");
  a_log_keep: assert property (p_log_keep) else $error("logged flag dropped");
  a_log_cause: assert property (p_log_cause) else $error("logged flag unprompted");
  a_clear: assert property (p_clear) else $error("clear failed");
  a_fresh: assert property (p_fresh) else $error("lost set on empty bank");
  c_over: cover property (err_valid && entry_logged);
  c_clear: cover property (hi_wr && pwdata[31:30] == 2'h0);
  c_lost: cover property ($rose(lost_error));
endmodule
bind mcl_logger mcl_logger_props #(.ADDR_W(ADDR_W)) mcl_logger_props_i (
  .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .err_valid(err_valid), .entry_logged(entry_logged),
  .lost_error(lost_error));

// ==== bench/tb.sv ====
// self-checking bench for the status logger
`timescale 1ns/1ns
module tb;
  // -----------------------------------------
  // signals and model
  // -----------------------------------------
  logic clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, err_loc = 32'h0, err_xtra = 32'h0;
  logic pready, pslverr, err_valid = 1'b0, err_uncorr = 1'b0, err_ctx = 1'b0;
  logic err_loc_ok = 1'b0, err_xtra_ok = 1'b0, entry_logged, lost_error;
  logic [1:0] err_xtra_fmt = 2'h0;
  logic [15:0] err_detail = 16'h0;
  mcl_pkg::mcl_kind_t err_kind = mcl_pkg::MCL_KIND_INTERNAL;
  logic [31:0] exp_hi = 32'h0, exp_lo = 32'h0, exp_loc, exp_x, q;
  logic [7:0] cnt = 8'h00;
  logic [2:0] permit = 3'h0;
  logic e;
  int failures = 0, tests_run = 0;
  always #50 clock = ~clock;
  mcl_logger mcl_logger_i (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .err_valid(err_valid), .err_kind(err_kind), .err_uncorr(err_uncorr),
    .err_ctx(err_ctx), .err_loc_ok(err_loc_ok), .err_loc(err_loc), .err_xtra_ok(err_xtra_ok),
    .err_xtra(err_xtra), .err_xtra_fmt(err_xtra_fmt), .err_detail(err_detail),
    .entry_logged(entry_logged), .lost_error(lost_error));
  // -----------------------------------------
  // tasks
  // -----------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // one apb transfer; an idle cycle follows so back-to-back calls never race
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge clock);
  endtask
  task clear_all;
    apb(1'b1, mcl_pkg::OFS_STAT_HI, 32'h0);
    apb(1'b1, mcl_pkg::OFS_STAT_LO, 32'h0);
    exp_hi = 32'h0;
    exp_lo = 32'h0;
  endtask
  task raise(input logic [1:0] k, input logic uc, input logic ctx, input logic ok,
             input logic [15:0] det);
    logic [15:0] code;
    code = k == 2'h1 ? mcl_pkg::CODE_L3_TAG : k == 2'h2 ? mcl_pkg::CODE_BUS : mcl_pkg::CODE_INTERNAL;
    err_kind <= mcl_pkg::mcl_kind_t'(k);
    {err_valid, err_uncorr, err_ctx, err_loc_ok, err_xtra_ok} <= {1'b1, uc, ctx, ok, ~ok};
    {err_loc, err_xtra, err_xtra_fmt, err_detail} <= {det, ~det, ~det, det, det[1:0], det};
    @(posedge clock);
    err_valid <= 1'b0;
    if (!uc && cnt != 8'hff) cnt++;
    if (exp_hi[31]) exp_hi[30] = 1'b1;
    // only an uncorrected error may displace a corrected entry
    if (!exp_hi[31] || (uc && !exp_hi[29])) begin
      exp_hi = {1'b1, exp_hi[30], uc, uc & permit[k == 2'h3 ? 2'h0 : k], ~ok, ok, uc | ctx,
                15'h0, det[1:0], cnt};
      exp_lo = {det, code};
      exp_loc = {det, ~det};
      exp_x = {~det, det};
    end
    @(posedge clock);
  endtask
  task verify;
    chk({31'h0, entry_logged}, {31'h0, exp_hi[31]});
    chk({31'h0, lost_error}, {31'h0, exp_hi[30]});
    apb(1'b0, mcl_pkg::OFS_STAT_LO, 32'h0);
    chk(q, exp_lo);
    apb(1'b0, mcl_pkg::OFS_STAT_HI, 32'h0);
    chk(q, exp_hi);
    if (exp_hi[26]) begin
      apb(1'b0, mcl_pkg::OFS_FAULT, 32'h0);
      chk(q, exp_loc);
    end
    if (exp_hi[27]) begin
      apb(1'b0, mcl_pkg::OFS_EXTRA, 32'h0);
      chk(q, exp_x);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // -----------------------------------------
  // sequence
  // -----------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    for (int a = 0; a < 6; a++) begin
      apb(1'b0, 12'(a * 4), 32'h0);
      chk(q, 32'h0);
      chk({31'h0, e}, {31'h0, a == 5});
    end
    apb(1'b1, mcl_pkg::OFS_PERMIT, 32'hffff_fffd);
    permit = 3'h5;
    apb(1'b0, mcl_pkg::OFS_PERMIT, 32'h0);
    chk(q, 32'h5);
    $display("test registers done");
    for (int k = 0; k < 3; k++) begin
      raise(2'(k), 1'b1, 1'b0, k[0], 16'h3a50 + 16'(k));
      verify;
      clear_all;
      verify;
    end
    $display("test codes done");
    raise(2'h2, 1'b0, 1'b1, 1'b1, 16'h1234);
    verify;
    raise(2'h0, 1'b0, 1'b0, 1'b0, 16'h5555);
    verify;
    raise(2'h1, 1'b1, 1'b0, 1'b1, 16'h0f0f);
    verify;
    raise(2'h0, 1'b1, 1'b1, 1'b0, 16'h7777);
    verify;
    $display("test priority done");
    apb(1'b1, mcl_pkg::OFS_STAT_HI, 32'hffff_ffff);
    verify;
    apb(1'b1, mcl_pkg::OFS_STAT_HI, 32'hbfff_ffff);
    exp_hi[30] = 1'b0;
    verify;
    clear_all;
    raise(2'h2, 1'b0, 1'b0, 1'b1, 16'h00c3);
    verify;
    clear_all;
    raise(2'h3, 1'b1, 1'b0, 1'b0, 16'h2468);
    verify;
    $display("test clear done");
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    end_of_test;
  end
endmodule
